// ==== rtl/lin_slave_frame_decoder.sv ====
`timescale 1ns/1ps
module lin_slave_frame_decoder (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic hdr_valid_in,
    input wire logic [7:0] hdr_id_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_byte_in,
    output logic tx_valid_out,
    output logic [7:0] tx_byte_out,
    input wire logic tx_ready_in,
    output logic cmd_valid_out,
    output lin_frame_pkg::cmd_s cmd_out
);

    logic [6:0] node_addr;
    logic [5:0] gp2_id;
    logic [5:0] gp4_id;
    logic [5:0] prep_id;
    logic [5:0] app_id;
    logic [5:0] node_cmd_id;
    logic [5:0] dread_id;
    logic [31:0] resp_lo;
    logic [23:0] resp_hi;
    logic [7:0] par_err_cnt;
    logic [7:0] sum_err_cnt;
    logic prep_pending;
    logic [6:0] prep_cmd;

    lin_frame_pkg::state_e state;
    lin_frame_pkg::frame_kind_e kind_q;
    logic [3:0] len_q;
    logic [3:0] cnt_q;
    logic [7:0] sum_q;
    logic [7:0][7:0] rx_data;

    function automatic logic [7:0] csum_add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        csum_add = t[7:0] + {7'h00, t[8]};
    endfunction

    // frame header decode
    wire [5:0] fid = hdr_id_in[5:0];
    wire par6 = fid[0] ^ fid[1] ^ fid[2] ^ fid[4];
    wire par7 = ~(fid[1] ^ fid[3] ^ fid[4] ^ fid[5]);
    wire par_ok = (hdr_id_in[6] == par6) && (hdr_id_in[7] == par7);
    wire [3:0] hdr_len = fid[5] ? (fid[4] ? lin_frame_pkg::LEN_LONG : lin_frame_pkg::LEN_MID)
                                : lin_frame_pkg::LEN_SHORT;

    // reserved identifiers win over software-assigned ones
    wire is_3c = (fid == lin_frame_pkg::ID_CMD_FRAME);
    wire is_3d = (fid == lin_frame_pkg::ID_INDIRECT_READ);
    wire is_dread = (fid == dread_id);
    wire is_prep = (fid == prep_id);
    wire is_gp = (fid == gp2_id) || (fid == gp4_id);
    wire is_app = (fid == app_id);
    wire is_node = (fid == node_cmd_id);

    lin_frame_pkg::frame_kind_e hdr_kind;
    always_comb begin
        if (is_3c) begin
            hdr_kind = lin_frame_pkg::K_CMD3C;
        end else if (is_3d) begin
            hdr_kind = lin_frame_pkg::K_IREAD;
        end else if (is_dread) begin
            hdr_kind = lin_frame_pkg::K_DREAD;
        end else if (is_prep) begin
            hdr_kind = lin_frame_pkg::K_PREP;
        end else if (is_gp) begin
            hdr_kind = lin_frame_pkg::K_GP;
        end else if (is_app) begin
            hdr_kind = lin_frame_pkg::K_APP;
        end else if (is_node) begin
            hdr_kind = lin_frame_pkg::K_NODE;
        end else begin
            hdr_kind = lin_frame_pkg::K_NONE;
        end
    end

    wire hdr_read = (hdr_kind == lin_frame_pkg::K_DREAD) ||
                    ((hdr_kind == lin_frame_pkg::K_IREAD) && prep_pending);
    wire hdr_rx = (hdr_kind != lin_frame_pkg::K_NONE) && (hdr_kind != lin_frame_pkg::K_DREAD)
                  && (hdr_kind != lin_frame_pkg::K_IREAD);
    wire hdr_go = hdr_valid_in && par_ok;
    wire hdr_bad = hdr_valid_in && !par_ok;
    wire [3:0] eff_len = (hdr_kind == lin_frame_pkg::K_NODE) ? lin_frame_pkg::LEN_SHORT : hdr_len;

    // receive side
    wire rx_take = (state == lin_frame_pkg::ST_RX) && rx_valid_in && !hdr_valid_in;
    wire rx_data_byte = rx_take && (cnt_q < len_q);
    wire rx_sum_byte = rx_take && (cnt_q == len_q);
    wire rx_sum_ok = rx_sum_byte && (rx_byte_in == ~sum_q);
    wire rx_sum_bad = rx_sum_byte && (rx_byte_in != ~sum_q);

    // dispatch of a completed writing frame
    wire addr_b1 = (rx_data[1][6:0] == node_addr);
    wire addr_b2 = (rx_data[2][6:0] == node_addr);
    wire gp_act = !rx_data[1][7] || addr_b1;
    wire c3c_bcast = !rx_data[0][7];
    wire c3c_act = (rx_data[0] == lin_frame_pkg::APP_CMD_MARKER) && addr_b2;
    wire prep_act = rx_data[0][7] && rx_data[1][7] && addr_b1;

    logic do_cmd;
    logic do_prep;
    lin_frame_pkg::frame_kind_e out_kind;
    logic [7:0] out_code;
    always_comb begin
        do_cmd = 1'b0;
        do_prep = 1'b0;
        out_kind = kind_q;
        out_code = rx_data[0];
        case (kind_q)
            lin_frame_pkg::K_GP: begin
                do_cmd = gp_act;
            end
            lin_frame_pkg::K_APP: begin
                do_cmd = 1'b1;
            end
            lin_frame_pkg::K_NODE: begin
                do_cmd = 1'b1;
            end
            lin_frame_pkg::K_CMD3C: begin
                if (c3c_bcast) begin
                    do_cmd = 1'b1;
                    out_kind = lin_frame_pkg::K_BCAST;
                end else begin
                    do_cmd = c3c_act;
                    do_prep = c3c_act;
                    out_code = rx_data[1];
                end
            end
            lin_frame_pkg::K_PREP: begin
                do_prep = prep_act;
                out_code = {1'b0, rx_data[0][6:0]};
            end
            default: begin
                do_cmd = 1'b0;
            end
        endcase
    end

    // transmit side: byte 0 is the node address with bit 7 set, later data bytes from the response words, last byte the inverted checksum
    wire [55:0] resp_bytes = {resp_hi, resp_lo};
    wire [7:0] tx_next_sum = csum_add(sum_q, tx_byte_out);
    wire [3:0] tx_next_idx = cnt_q + 4'h1;
    wire [5:0] tx_sel = {tx_next_idx[2:0] - 3'h1, 3'h0};
    wire [7:0] tx_next_byte = (tx_next_idx == len_q) ? ~tx_next_sum : resp_bytes[tx_sel +: 8];
    wire [7:0] tx_first_byte = {1'b1, node_addr};
    wire tx_accept = (state == lin_frame_pkg::ST_TX) && tx_ready_in && !hdr_valid_in;
    wire tx_last = tx_accept && (cnt_q == len_q);

    assign tx_valid_out = (state == lin_frame_pkg::ST_TX);

    // frame state machine; a new header always restarts it
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= lin_frame_pkg::ST_IDLE;
            kind_q <= lin_frame_pkg::K_NONE;
            len_q <= 4'h0;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
            tx_byte_out <= 8'h00;
        end else if (hdr_go && hdr_read) begin
            state <= lin_frame_pkg::ST_TX;
            kind_q <= hdr_kind;
            len_q <= hdr_kind == lin_frame_pkg::K_IREAD ? lin_frame_pkg::LEN_LONG : hdr_len;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
            tx_byte_out <= tx_first_byte;
        end else if (hdr_go && hdr_rx) begin
            state <= lin_frame_pkg::ST_RX;
            kind_q <= hdr_kind;
            len_q <= eff_len;
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (hdr_valid_in) begin
            state <= lin_frame_pkg::ST_SKIP;
            kind_q <= lin_frame_pkg::K_NONE;
        end else if (rx_data_byte) begin
            cnt_q <= cnt_q + 4'h1;
            sum_q <= csum_add(sum_q, rx_byte_in);
        end else if (rx_sum_byte || tx_last) begin
            state <= lin_frame_pkg::ST_IDLE;
        end else if (tx_accept) begin
            cnt_q <= tx_next_idx;
            sum_q <= tx_next_sum;
            tx_byte_out <= tx_next_byte;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_data <= '0;
        end else if (hdr_go) begin
            rx_data <= '0;
        end else if (rx_data_byte) begin
            rx_data[cnt_q[2:0]] <= rx_byte_in;
        end
    end

    // every header drops the pending request; only a good preparing frame or an addressed 0x3C command frame sets it
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prep_pending <= 1'b0;
            prep_cmd <= 7'h00;
        end else if (rx_sum_ok && do_prep) begin
            prep_pending <= 1'b1;
            prep_cmd <= out_code[6:0];
        end else if (hdr_valid_in) begin
            prep_pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_valid_out <= 1'b0;
            cmd_out <= '0;
        end else if (hdr_go && hdr_read) begin
            cmd_valid_out <= 1'b1;
            cmd_out.kind <= hdr_kind;
            cmd_out.code <= hdr_kind == lin_frame_pkg::K_IREAD ? {1'b0, prep_cmd} : 8'h00;
            cmd_out.data <= '0;
        end else if (rx_sum_ok && do_cmd) begin
            cmd_valid_out <= 1'b1;
            cmd_out.kind <= out_kind;
            cmd_out.code <= out_code;
            cmd_out.data <= rx_data;
        end else begin
            cmd_valid_out <= 1'b0;
        end
    end

    // register port
    wire wr_node = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_NODE_ADDR);
    wire wr_gp2 = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_GP2_ID);
    wire wr_gp4 = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_GP4_ID);
    wire wr_prep = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_PREP_ID);
    wire wr_app = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_APP_ID);
    wire wr_ncmd = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_NODE_CMD_ID);
    wire wr_dread = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_DREAD_ID);
    wire wr_rlo = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_RESP_LO);
    wire wr_rhi = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_RESP_HI);
    wire wr_stat = reg_wr_in && (reg_addr_in == lin_frame_pkg::OFS_STATUS);

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            node_addr <= lin_frame_pkg::RST_NODE_ADDR;
            gp2_id <= lin_frame_pkg::RST_GP2_ID;
            gp4_id <= lin_frame_pkg::RST_GP4_ID;
            prep_id <= lin_frame_pkg::RST_PREP_ID;
            app_id <= lin_frame_pkg::RST_APP_ID;
            node_cmd_id <= lin_frame_pkg::RST_NODE_CMD_ID;
            dread_id <= lin_frame_pkg::RST_DREAD_ID;
            resp_lo <= 32'h0000_0000;
            resp_hi <= 24'h00_0000;
        end else begin
            if (wr_node) node_addr <= reg_wdata_in[6:0];
            if (wr_gp2) gp2_id <= reg_wdata_in[5:0];
            if (wr_gp4) gp4_id <= reg_wdata_in[5:0];
            if (wr_prep) prep_id <= reg_wdata_in[5:0];
            if (wr_app) app_id <= reg_wdata_in[5:0];
            if (wr_ncmd) node_cmd_id <= reg_wdata_in[5:0];
            if (wr_dread) dread_id <= reg_wdata_in[5:0];
            if (wr_rlo) resp_lo <= reg_wdata_in;
            if (wr_rhi) resp_hi <= reg_wdata_in[23:0];
        end
    end

    // error counters: a same-cycle event is counted after the clear so nothing is lost
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            par_err_cnt <= 8'h00;
            sum_err_cnt <= 8'h00;
        end else begin
            if (hdr_bad) begin
                par_err_cnt <= wr_stat ? 8'h01 : par_err_cnt + 8'h01;
            end else if (wr_stat) begin
                par_err_cnt <= 8'h00;
            end
            if (rx_sum_bad) begin
                sum_err_cnt <= wr_stat ? 8'h01 : sum_err_cnt + 8'h01;
            end else if (wr_stat) begin
                sum_err_cnt <= 8'h00;
            end
        end
    end

    wire [31:0] status_word = {state, kind_q, prep_pending, prep_cmd, sum_err_cnt, par_err_cnt};

    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr_in)
            lin_frame_pkg::OFS_NODE_ADDR: rd_mux = {25'h0, node_addr};
            lin_frame_pkg::OFS_GP2_ID: rd_mux = {26'h0, gp2_id};
            lin_frame_pkg::OFS_GP4_ID: rd_mux = {26'h0, gp4_id};
            lin_frame_pkg::OFS_PREP_ID: rd_mux = {26'h0, prep_id};
            lin_frame_pkg::OFS_APP_ID: rd_mux = {26'h0, app_id};
            lin_frame_pkg::OFS_NODE_CMD_ID: rd_mux = {26'h0, node_cmd_id};
            lin_frame_pkg::OFS_DREAD_ID: rd_mux = {26'h0, dread_id};
            lin_frame_pkg::OFS_RESP_LO: rd_mux = resp_lo;
            lin_frame_pkg::OFS_RESP_HI: rd_mux = {8'h00, resp_hi};
            lin_frame_pkg::OFS_STATUS: rd_mux = status_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule

// ==== inc/lin_frame_pkg.sv ====
package lin_frame_pkg;

    localparam logic [7:0] OFS_NODE_ADDR = 8'h00;
    localparam logic [7:0] OFS_GP2_ID = 8'h04;
    localparam logic [7:0] OFS_GP4_ID = 8'h08;
    localparam logic [7:0] OFS_PREP_ID = 8'h0C;
    localparam logic [7:0] OFS_APP_ID = 8'h10;
    localparam logic [7:0] OFS_NODE_CMD_ID = 8'h14;
    localparam logic [7:0] OFS_DREAD_ID = 8'h18;
    localparam logic [7:0] OFS_RESP_LO = 8'h1C;
    localparam logic [7:0] OFS_RESP_HI = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    localparam logic [6:0] RST_NODE_ADDR = 7'h00;
    localparam logic [5:0] RST_GP2_ID = 6'h18;
    localparam logic [5:0] RST_GP4_ID = 6'h28;
    localparam logic [5:0] RST_PREP_ID = 6'h1A;
    localparam logic [5:0] RST_APP_ID = 6'h10;
    localparam logic [5:0] RST_NODE_CMD_ID = 6'h09;
    localparam logic [5:0] RST_DREAD_ID = 6'h20;

    localparam logic [5:0] ID_CMD_FRAME = 6'h3C;
    localparam logic [5:0] ID_INDIRECT_READ = 6'h3D;
    localparam logic [7:0] APP_CMD_MARKER = 8'h80;
    localparam logic [3:0] LEN_SHORT = 4'h2;
    localparam logic [3:0] LEN_MID = 4'h4;
    localparam logic [3:0] LEN_LONG = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RX = 4'b0010,
        ST_TX = 4'b0100,
        ST_SKIP = 4'b1000
    } state_e;

    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_GP = 4'h1,
        K_APP = 4'h2,
        K_NODE = 4'h3,
        K_CMD3C = 4'h4,
        K_BCAST = 4'h5,
        K_PREP = 4'h6,
        K_DREAD = 4'h7,
        K_IREAD = 4'h8
    } frame_kind_e;

    typedef struct packed {
        frame_kind_e kind;
        logic [7:0] code;
        logic [7:0][7:0] data;
    } cmd_s;

endpackage

// ==== verif/lin_frame_chk.sv ====
`timescale 1ns/1ps
module lin_frame_chk (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic hdr_valid_in,
    input wire logic [7:0] hdr_id_in,
    input wire logic tx_valid_out,
    input wire logic [7:0] tx_byte_out,
    input wire logic tx_ready_in,
    input wire logic cmd_valid_out,
    input wire lin_frame_pkg::cmd_s cmd_out
);
    logic [6:0] addr;
    logic [3:0] len;
    logic [3:0] cnt;
    logic [7:0] sum;
    wire [5:0] id = hdr_id_in[5:0];
    wire bad_par = hdr_id_in[6] != (id[0] ^ id[1] ^ id[2] ^ id[4])
        || hdr_id_in[7] == (id[1] ^ id[3] ^ id[4] ^ id[5]);
    wire [3:0] next_len = (id == 6'h3D || id[5:4] == 2'h3) ? 4'h8 : (id[5] ? 4'h4 : 4'h2);
    wire took = tx_valid_out && tx_ready_in;
    wire [8:0] add = sum + tx_byte_out;
    // own copy of the node address, so the response byte can be judged
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr <= lin_frame_pkg::RST_NODE_ADDR;
        end else if (reg_wr_in && reg_addr_in == lin_frame_pkg::OFS_NODE_ADDR) begin
            addr <= reg_wdata_in[6:0];
        end
    end
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            len <= 4'h0;
            cnt <= 4'h0;
            sum <= 8'h00;
        end else if (hdr_valid_in) begin
            len <= next_len;
            cnt <= 4'h0;
            sum <= 8'h00;
        end else if (took) begin
            cnt <= cnt + 4'h1;
            sum <= (cnt < len) ? add[7:0] + {7'h00, add[8]} : sum;
        end
    end
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    chk_parity_mute: assert property (
        hdr_valid_in && bad_par |=> !tx_valid_out && !cmd_valid_out)
        else $error("action after a corrupted identifier");
    chk_resp_addr: assert property (
        $rose(tx_valid_out) |-> tx_byte_out == {1'h1, addr})
        else $error("first response byte lacks node address");
    chk_resp_start: assert property (
        $rose(tx_valid_out) |-> $past(hdr_valid_in))
        else $error("response not started by a header");
    chk_byte_hold: assert property (
        tx_valid_out && !tx_ready_in && !hdr_valid_in |=> tx_valid_out && $stable(tx_byte_out))
        else $error("response byte dropped before taken");
    chk_resp_len: assert property (
        $fell(tx_valid_out) && !$past(hdr_valid_in) |-> cnt == len + 4'h1)
        else $error("response byte count wrong");
    chk_resp_sum: assert property (
        tx_valid_out && cnt == len |-> tx_byte_out == ~sum)
        else $error("response checksum wrong");
    chk_gp_code: assert property (
        cmd_valid_out && cmd_out.kind == lin_frame_pkg::K_GP |-> cmd_out.code == cmd_out.data[0])
        else $error("general command code not from first byte");
    chk_gp_addr: assert property (
        cmd_valid_out && cmd_out.kind == lin_frame_pkg::K_GP && cmd_out.data[1][7]
        |-> cmd_out.data[1][6:0] == addr)
        else $error("addressed general command for another node");
    chk_cmd_fields: assert property (
        cmd_valid_out && cmd_out.kind == lin_frame_pkg::K_CMD3C
        |-> cmd_out.data[0] == 8'h80 && cmd_out.code == cmd_out.data[1])
        else $error("command frame fields wrong");
    chk_bcast_low: assert property (
        cmd_valid_out && cmd_out.kind == lin_frame_pkg::K_BCAST |-> !cmd_out.data[0][7])
        else $error("broadcast with marker bit set");
    chk_read_pulse: assert property (
        cmd_valid_out && cmd_out.kind inside {lin_frame_pkg::K_DREAD, lin_frame_pkg::K_IREAD}
        |-> $rose(tx_valid_out))
        else $error("read command without response start");
endmodule
bind lin_slave_frame_decoder lin_frame_chk i_chk (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .hdr_valid_in(hdr_valid_in),
    .hdr_id_in(hdr_id_in), .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
    .tx_ready_in(tx_ready_in), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out)
);

// ==== verif/lin_master_model.sv ====
`timescale 1ns/1ps
module lin_master_model (
    input wire logic clk_in,
    output logic hdr_valid_out,
    output logic [7:0] hdr_id_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic tx_ready_out,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_byte_in
);
    logic slow = 1'h0;
    logic [7:0] rbuf [16];
    int rcnt = 0;
    initial begin
        hdr_valid_out = 1'h0;
        hdr_id_out = 8'h00;
        rx_valid_out = 1'h0;
        rx_byte_out = 8'h00;
        tx_ready_out = 1'h0;
    end
    function automatic logic [7:0] par(input logic [5:0] id);
        par = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction
    function automatic logic [7:0] ck(input logic [63:0] d, input int n);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < n; i++) begin
            s = s[7:0] + d[8*i+:8];
            s = s[7:0] + s[8];
        end
        ck = ~s[7:0];
    endfunction
    // n of 0 is a read header: the master then only listens
    task automatic send(input logic [5:0] id, input int n, input logic [63:0] d,
                        input logic [1:0] bad);
        @(posedge clk_in);
        hdr_valid_out <= 1'h1;
        hdr_id_out <= par(id) ^ {bad[0], 7'h00};
        for (int i = 0; i < (n > 0 ? n + 1 : 0); i++) begin
            @(posedge clk_in);
            hdr_valid_out <= 1'h0;
            rx_valid_out <= 1'h1;
            rx_byte_out <= i < n ? d[8*i+:8] : ck(d, n) ^ {8{bad[1]}};
        end
        @(posedge clk_in);
        hdr_valid_out <= 1'h0;
        hdr_id_out <= ~hdr_id_out;
        rx_valid_out <= 1'h0;
        rx_byte_out <= ~rx_byte_out;
    endtask
    // slow mode takes a byte only every other cycle to stress the hold
    always @(posedge clk_in) begin
        tx_ready_out <= slow ? ~tx_ready_out : 1'h1;
        if (hdr_valid_out) begin
            rcnt <= 0;
        end else if (tx_valid_in && tx_ready_out) begin
            rbuf[rcnt] <= tx_byte_in;
            rcnt <= rcnt + 1;
        end
    end
endmodule

// ==== verif/lin_slave_frame_decoder_bench.sv ====
`timescale 1ns/1ps
module lin_slave_frame_decoder_bench;
    typedef struct packed {
        logic [5:0] id;
        logic [3:0] n;
        logic [1:0] bad;
        logic [63:0] d;
        logic v;
        logic [3:0] kind;
        logic [7:0] code;
    } row_s;
    logic core_clk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic [31:0] reg_rdata_out;
    logic hdr_valid_in, rx_valid_in, tx_ready_in, tx_valid_out, cmd_valid_out;
    logic [7:0] hdr_id_in, rx_byte_in, tx_byte_out;
    lin_frame_pkg::cmd_s cmd_out, last;
    int num_errors = 0;
    int n_tests = 0;
    int npulse = 0;
    int p;
    row_s rows [12];
    logic [41:0] rst_ids = {6'h20, 6'h09, 6'h10, 6'h1A, 6'h28, 6'h18, 6'h00};
    always #50 core_clk_in = ~core_clk_in;
    lin_slave_frame_decoder i_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .hdr_valid_in(hdr_valid_in),
        .hdr_id_in(hdr_id_in), .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
        .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out), .tx_ready_in(tx_ready_in),
        .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out));
    lin_master_model i_master (.clk_in(core_clk_in), .hdr_valid_out(hdr_valid_in),
        .hdr_id_out(hdr_id_in), .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in),
        .tx_ready_out(tx_ready_in), .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out));
    always @(posedge core_clk_in) begin
        if (cmd_valid_out === 1'h1) begin
            npulse <= npulse + 1;
            last <= cmd_out;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'h0;
        @(negedge core_clk_in);
        check(64'(reg_rdata_out), 64'(exp));
    endtask
    // n of 0 means no answer may come at all
    task automatic rframe(input logic [5:0] id, input int n, input logic [63:0] exp);
        int k;
        i_master.send(id, 0, 64'h0, 2'h0);
        @(negedge core_clk_in);
        for (k = 0; k < 4 && !tx_valid_out; k++) @(negedge core_clk_in);
        for (k = 0; k < 200 && tx_valid_out; k++) @(negedge core_clk_in);
        if (k == 200) begin
            num_errors++;
            tally_and_finish();
        end
        check(64'(i_master.rcnt), 64'(n > 0 ? n + 1 : 0));
        for (k = 0; k < n + 1 && n > 0; k++) begin
            check(64'(i_master.rbuf[k]), 64'(k < n ? exp[8*k+:8] : i_master.ck(exp, n)));
        end
    endtask
    initial begin
        rows[0] = '{6'h18, 4'h2, 2'h0, 64'h0533, 1'h1, 4'h1, 8'h33};
        rows[1] = '{6'h18, 4'h2, 2'h0, 64'h9533, 1'h1, 4'h1, 8'h33};
        rows[2] = '{6'h18, 4'h2, 2'h0, 64'h9633, 1'h0, 4'h0, 8'h00};
        rows[3] = '{6'h28, 4'h4, 2'h0, 64'h7856_9541, 1'h1, 4'h1, 8'h41};
        rows[4] = '{6'h10, 4'h2, 2'h0, 64'h1234, 1'h1, 4'h2, 8'h00};
        rows[5] = '{6'h09, 4'h2, 2'h0, 64'h5678, 1'h1, 4'h3, 8'h00};
        rows[6] = '{6'h3C, 4'h8, 2'h0, 64'hFFFF_FFFF_FF95_4580, 1'h1, 4'h4, 8'h45};
        rows[7] = '{6'h3C, 4'h8, 2'h0, 64'hFFFF_FFFF_FF95_4500, 1'h1, 4'h5, 8'h00};
        rows[8] = '{6'h3C, 4'h8, 2'h0, 64'hFFFF_FFFF_FF96_4580, 1'h0, 4'h0, 8'h00};
        rows[9] = '{6'h18, 4'h2, 2'h1, 64'h0533, 1'h0, 4'h0, 8'h00};
        rows[10] = '{6'h18, 4'h2, 2'h2, 64'h0533, 1'h0, 4'h0, 8'h00};
        rows[11] = '{6'h3C, 4'h8, 2'h0, 64'hFFFF_FFFF_FF95_457F, 1'h1, 4'h5, 8'h00};
        repeat (2) @(posedge core_clk_in);
        check(64'({tx_valid_out, cmd_valid_out, reg_rdata_out}), 64'h0);
        nrst_in <= 1'h1;
        for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'(rst_ids[6*i+:6]));
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        wr(lin_frame_pkg::OFS_NODE_ADDR, 32'hFFFF_FF95);
        rd(lin_frame_pkg::OFS_NODE_ADDR, 32'h15);
        foreach (rows[i]) begin
            p = npulse;
            i_master.send(rows[i].id, 32'(rows[i].n), rows[i].d, rows[i].bad);
            repeat (2) @(negedge core_clk_in);
            check(64'(npulse - p), 64'(rows[i].v));
            if (rows[i].v) begin
                check(64'(last.kind), 64'(rows[i].kind));
                check(last.data & ~({64{1'h1}} << 8 * rows[i].n), rows[i].d);
                if (rows[i].kind inside {4'h1, 4'h4}) check(64'(last.code), 64'(rows[i].code));
            end
        end
        // one corrupted header and one bad checksum were sent above; the write clears both counts
        rd(lin_frame_pkg::OFS_STATUS, 32'h1445_0101);
        wr(lin_frame_pkg::OFS_STATUS, 32'h0);
        rd(lin_frame_pkg::OFS_STATUS, 32'h1445_0000);
        i_master.slow = 1'h1;
        wr(lin_frame_pkg::OFS_RESP_LO, 32'h4433_2211);
        wr(lin_frame_pkg::OFS_RESP_HI, 32'h0077_6655);
        rframe(6'h20, 4, 64'h3322_1195);
        check(64'(last.kind), 64'h7);
        rframe(6'h3D, 0, 64'h0);
        i_master.send(6'h1A, 2, 64'h9592, 2'h0);
        rframe(6'h3D, 8, 64'h7766_5544_3322_1195);
        check(64'({last.kind, last.code}), 64'h812);
        i_master.send(6'h1A, 2, 64'h9592, 2'h0);
        i_master.send(6'h18, 2, 64'h0533, 2'h0);
        rframe(6'h3D, 0, 64'h0);
        tally_and_finish();
    end
endmodule
